//--- verification/test_two_wire_event_sequencer.sv
// testbench: register rows, slave receive, masked stop, nack before stop
`timescale 1ns/1ns
`default_nettype none
module test_two_wire_event_sequencer;
  import twes_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } twes_row_t;
  localparam twes_row_t ROWS [10] = '{
    '{TWES_OFF_CTRL, 1'h0, 32'h0, 32'(TWES_CTRL_RST), 1'h0},
    '{TWES_OFF_DATA, 1'h0, 32'h0, 32'(TWES_DATA_RST), 1'h0},
    '{TWES_OFF_IRQST, 1'h0, 32'h0, 32'h0, 1'h0},
    '{TWES_OFF_IRQMK, 1'h0, 32'h0, 32'h0, 1'h0},
    '{TWES_OFF_DATA, 1'h1, 32'ha5, 32'h0, 1'h0},
    '{TWES_OFF_DATA, 1'h0, 32'h0, 32'ha5, 1'h0},
    '{TWES_OFF_IRQMK, 1'h1, 32'hfd, 32'h0, 1'h0},
    '{TWES_OFF_IRQMK, 1'h0, 32'h0, 32'h5, 1'h0},
    '{8'h10, 1'h1, 32'hff, 32'h0, 1'h1},
    '{8'h14, 1'h0, 32'h0, 32'h0, 1'h1}};
  logic          clk_in;
  logic          srst_in;
  twes_apb_req_t apb_in;
  logic          pready_w;
  logic          pslverr_w;
  logic [31:0]   prdata_w;
  logic          scl_oe_w;
  logic          sda_oe_w;
  logic          scl_low;
  logic          sda_low;
  logic          ev_w;
  logic          irq_w;
  logic [31:0]   rdq;
  logic          errq;
  logic          a0;
  logic          a1;
  int            ev_count = 0;
  int            fail_count = 0;
  int            cmp_count = 0;
  wire logic       scl_lvl = !(scl_oe_w | scl_low);
  wire logic       sda_lvl = !(sda_oe_w | sda_low);
  wire twes_pins_t pins_w  = {scl_lvl, sda_lvl};
  twes_top i_dut (.clk_in(clk_in), .srst_in(srst_in), .apb_in(apb_in), .pready_out(pready_w),
    .pslverr_out(pslverr_w), .prdata_out(prdata_w), .pins_in(pins_w), .own_addr_in(7'h2a),
    .scl_out(), .scl_oe_out(scl_oe_w), .sda_out(), .sda_oe_out(sda_oe_w),
    .event_pulse_out(ev_w), .irq_out(irq_w));
  twes_peer i_peer (.clk_in(clk_in), .scl_in(scl_lvl), .sda_in(sda_lvl),
    .scl_low_out(scl_low), .sda_low_out(sda_low));
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
    if (ev_w === 1'b1)
      ev_count <= ev_count + 1;
  // ******
  // shared tasks
  // ******
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    apb_in <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    apb_in.penable <= 1'b1;
    @(posedge clk_in);
    while (pready_w !== 1'b1 && k < 50)
    begin
      @(posedge clk_in);
      k++;
    end
    rdq = prdata_w;
    errq = pslverr_w;
    apb_in <= '0;
    @(posedge clk_in);
    if (k == 50)
    begin
      fail_count++;
      complete_run();
    end
  endtask : bus
  // waits for the interrupt, checks the settled registers, then proceeds
  task automatic svc(input logic [7:0] dq, input logic [7:0] cq, input logic [7:0] nc);
    int k;
    k = 0;
    while (irq_w !== 1'b1 && k < 5000)
    begin
      @(posedge clk_in);
      k++;
    end
    check("irq", 32'(irq_w), 32'h1);
    bus(TWES_OFF_DATA, 1'b0, 32'h0);
    check("data", rdq, 32'(dq));
    bus(TWES_OFF_CTRL, 1'b0, 32'h0);
    check("ctrl", rdq, 32'(cq));
    bus(TWES_OFF_IRQST, 1'b0, 32'h0);
    check("status", rdq, 32'h1);
    bus(TWES_OFF_IRQST, 1'b1, 32'h7);
    check("irq clear", 32'(irq_w), 32'h0);
    bus(TWES_OFF_CTRL, 1'b1, 32'(nc));
    if (k == 5000)
      complete_run();
  endtask : svc
  // ******
  // main sequence
  // ******
  initial
  begin
    srst_in = 1'b1;
    apb_in = '0;
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    foreach (ROWS[i])
    begin
      bus(ROWS[i].a, ROWS[i].w, ROWS[i].d);
      if (!ROWS[i].w)
        check("rdata", rdq, ROWS[i].q);
      check("pslverr", 32'(errq), 32'(ROWS[i].e));
    end
    $display("register rows done");
    bus(TWES_OFF_CTRL, 1'b1, 32'h90);
    bus(TWES_OFF_IRQMK, 1'b1, 32'h7);
    fork
      begin
        i_peer.start_cond();
        i_peer.send_byte(8'h54, a0);
        i_peer.send_byte(8'h3c, a1);
      end
      begin
        svc(8'h54, 8'h98, 8'h91);
        svc(8'h3c, 8'h90, 8'h91);
      end
    join
    check("address ack", 32'(a0), 32'h1);
    check("data ack", 32'(a1), 32'h1);
    check("byte pulses", 32'(ev_count), 32'h2);
    bus(TWES_OFF_IRQMK, 1'b1, 32'h0);
    i_peer.stop_cond();
    repeat (40) @(posedge clk_in);
    check("stop pulse", 32'(ev_count), 32'h3);
    check("masked irq", 32'(irq_w), 32'h0);
    bus(TWES_OFF_CTRL, 1'b0, 32'h0);
    check("stop ctrl", rdq, 32'hb0);
    bus(TWES_OFF_IRQMK, 1'b1, 32'h7);
    check("unmasked irq", 32'(irq_w), 32'h1);
    bus(TWES_OFF_CTRL, 1'b1, 32'h00);
    check("disabled irq", 32'(irq_w), 32'h0);
    bus(TWES_OFF_CTRL, 1'b1, 32'h90);
    check("enabled irq", 32'(irq_w), 32'h1);
    bus(TWES_OFF_IRQST, 1'b1, 32'h2);
    check("cleared irq", 32'(irq_w), 32'h0);
    $display("slave receive done");
    fork
      begin
        i_peer.start_cond();
        i_peer.send_byte(8'h54, a0);
        i_peer.send_byte(8'h0f, a1);
      end
      begin
        // received-stop flag stays until the next proceed write
        svc(8'h54, 8'hb8, 8'h81);
        svc(8'h0f, 8'h80, 8'h81);
      end
    join
    check("nack", 32'(a1), 32'h0);
    i_peer.stop_cond();
    repeat (40) @(posedge clk_in);
    check("no stop pulse", 32'(ev_count), 32'h5);
    check("link stalls", 32'(i_peer.stall_count), 32'h0);
    $display("nack stop done");
    complete_run();
  end
  initial
  begin
    repeat (90000) @(posedge clk_in);
    fail_count++;
    complete_run();
  end
endmodule : test_two_wire_event_sequencer
`default_nettype wire

//--- verification/twes_chk.sv
// checker: port-level assertions of the two-wire event sequencer
`timescale 1ns/1ns
`default_nettype none
module twes_chk
  import twes_pkg::*;
(
  input wire logic                    clk_in,
  input wire logic                    srst_in,
  input wire twes_pkg::twes_apb_req_t apb_in,
  input wire logic                    pready_out,
  input wire logic                    pslverr_out,
  input wire logic [31:0]             prdata_out,
  input wire logic                    event_pulse_out,
  input wire logic                    irq_out
);
  // ******
  // decode and properties
  // ******
  wire logic acc_w = apb_in.psel & apb_in.penable;
  wire logic map_w = (apb_in.paddr[7:4] == 4'h0) & (apb_in.paddr[1:0] == 2'h0);
  wire logic wr_w  = acc_w & apb_in.pwrite;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  pulse_single_a: assert property (event_pulse_out |=> !event_pulse_out)
    else $error("event pulse too long");
  zero_wait_a: assert property (pready_out)
    else $error("pready low");
  mapped_ok_a: assert property (acc_w & map_w |-> !pslverr_out)
    else $error("error on mapped access");
  unmapped_err_a: assert property (acc_w & !map_w |-> pslverr_out)
    else $error("no error on unmapped access");
  unmapped_zero_a: assert property (
    apb_in.psel & !apb_in.penable & !apb_in.pwrite & !map_w |=> prdata_out == 32'h0)
    else $error("unmapped read not zero");
  irq_cause_a: assert property (
    $rose(irq_out) |-> event_pulse_out || $past(event_pulse_out) || $past(wr_w))
    else $error("irq rose without cause");
  clear_drop_a: assert property (
    wr_w && apb_in.paddr == TWES_OFF_IRQST && apb_in.pwdata[2:0] == 3'h7
    |=> !irq_out || event_pulse_out)
    else $error("irq kept after clear");
  mask_drop_a: assert property (
    wr_w && apb_in.paddr == TWES_OFF_IRQMK && apb_in.pwdata[2:0] == 3'h0 |=> !irq_out)
    else $error("irq kept after mask");
  ien_drop_a: assert property (
    wr_w && apb_in.paddr == TWES_OFF_CTRL && !apb_in.pwdata[7] |=> !irq_out)
    else $error("irq kept with enable off");
  cover property (event_pulse_out);
  cover property ($rose(irq_out));
  cover property (acc_w & !map_w);
endmodule : twes_chk
bind twes_top twes_chk i_chk (.clk_in, .srst_in, .apb_in, .pready_out, .pslverr_out,
  .prdata_out, .event_pulse_out, .irq_out);
`default_nettype wire

//--- verification/twes_peer.sv
// partner: behavioural two-wire bus master, honours clock stretching
`timescale 1ns/1ns
`default_nettype none
module twes_peer
(
  input  wire logic clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var logic  scl_low_out,
  output var logic  sda_low_out
);
  // ******
  // bus cycles, 8 cycles a bit unless stretched
  // ******
  int stall_count = 0;
  initial
  begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask : hold
  task automatic wait_high();
    int k;
    k = 0;
    hold(1);
    while (!scl_in && k < 5000)
    begin
      hold(1);
      k++;
    end
    if (k == 5000)
      stall_count++;
  endtask : wait_high
  task automatic put_bit(input logic b, output logic r);
    sda_low_out <= !b;
    hold(2);
    scl_low_out <= 1'b0;
    wait_high();
    hold(3);
    r = sda_in;
    scl_low_out <= 1'b1;
    hold(2);
  endtask : put_bit
  task automatic start_cond();
    sda_low_out <= 1'b1;
    hold(4);
    scl_low_out <= 1'b1;
    hold(2);
  endtask : start_cond
  // msb first, then releases data for the acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = !r;
  endtask : send_byte
  task automatic stop_cond();
    sda_low_out <= 1'b1;
    hold(2);
    scl_low_out <= 1'b0;
    wait_high();
    hold(4);
    sda_low_out <= 1'b0;
    hold(4);
  endtask : stop_cond
endmodule : twes_peer
`default_nettype wire

//--- verilog/twes_pkg.sv
// package: register map, fields and constants of the two-wire event sequencer
package twes_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] TWES_OFF_CTRL  = 8'h00;
  localparam logic [7:0] TWES_OFF_DATA  = 8'h04;
  localparam logic [7:0] TWES_OFF_IRQST = 8'h08;
  localparam logic [7:0] TWES_OFF_IRQMK = 8'h0c;

  // ****************************************
  // control/status register bit positions
  // ****************************************
  localparam int TWES_B_PROCEED  = 0;
  localparam int TWES_B_XMIT     = 1;
  localparam int TWES_B_ARB_RS   = 2;
  localparam int TWES_B_ADDR     = 3;
  localparam int TWES_B_ACK      = 4;
  localparam int TWES_B_RSTOP    = 5;
  localparam int TWES_B_ROLE     = 6;
  localparam int TWES_B_IEN      = 7;

  // ****************************************
  // interrupt status bits
  // ****************************************
  localparam int TWES_EV_BYTE = 0;
  localparam int TWES_EV_STOP = 1;
  localparam int TWES_EV_ARB  = 2;
  localparam int TWES_EV_W    = 3;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [7:0] TWES_CTRL_RST  = 8'h00;
  localparam logic [7:0] TWES_DATA_RST  = 8'h00;
  localparam int         TWES_CLK_MHZ   = 250;
  localparam int         TWES_TLOW_NS   = 1300;
  localparam int         TWES_THALF_CYC = (TWES_TLOW_NS * TWES_CLK_MHZ + 999) / 1000;
  localparam logic [9:0] TWES_THALF     = 10'(TWES_THALF_CYC);

  typedef enum logic [3:0] {
    TWES_IDLE, TWES_M_START, TWES_M_BIT, TWES_M_ACK, TWES_M_WAIT,
    TWES_M_STOP, TWES_S_BIT, TWES_S_ACK, TWES_S_WAIT, TWES_ARB_WAIT
  } twes_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } twes_apb_req_t;

  typedef struct packed {
    logic scl_in;
    logic sda_in;
  } twes_pins_t;

endpackage : twes_pkg

//--- verilog/twes_top.sv
// two-wire event sequencer: byte engine, event flags, apb registers
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module twes_top
  import twes_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    srst_in,
  input  wire twes_pkg::twes_apb_req_t apb_in,
  output logic                         pready_out,
  output logic                         pslverr_out,
  output logic [31:0]                  prdata_out,
  input  wire twes_pkg::twes_pins_t    pins_in,
  input  wire logic [6:0]              own_addr_in,
  output logic                         scl_out,
  output logic                         scl_oe_out,
  output logic                         sda_out,
  output logic                         sda_oe_out,
  output logic                         event_pulse_out,
  output logic                         irq_out
);
  import twes_pkg::*;

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_q;
  logic       sda_q;
  always_ff @(posedge clk_in)
  begin
    scl_sync_q <= {scl_sync_q[0], pins_in.scl_in};
    sda_sync_q <= {sda_sync_q[0], pins_in.sda_in};
    scl_q      <= scl_sync_q[1];
    sda_q      <= sda_sync_q[1];
  end
  wire scl_s    = scl_sync_q[1];
  wire sda_s    = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

  // ****************************************
  // apb decode
  // ****************************************
  wire acc      = apb_in.psel & apb_in.penable;
  wire wr       = acc & apb_in.pwrite;
  wire hit_ctrl = apb_in.paddr == TWES_OFF_CTRL;
  wire hit_data = apb_in.paddr == TWES_OFF_DATA;
  wire hit_ist  = apb_in.paddr == TWES_OFF_IRQST;
  wire hit_imk  = apb_in.paddr == TWES_OFF_IRQMK;
  wire hit_any  = hit_ctrl | hit_data | hit_ist | hit_imk;
  wire wr_ctrl  = wr & hit_ctrl;
  wire wr_data  = wr & hit_data;
  wire [7:0] wd = apb_in.pwdata[7:0];
  wire go       = wr_ctrl & wd[TWES_B_PROCEED];
  assign pready_out  = 1'b1;
  assign pslverr_out = acc & ~hit_any;

  // ****************************************
  // registers and engine state
  // ****************************************
  twes_state_t     st_q;
  logic [7:0]      ctrl_q;
  logic [7:0]      data_q;
  logic [7:0]      sh_q;
  logic [3:0]      bit_q;
  logic [9:0]      tmr_q;
  logic            first_q;
  logic            sel_q;
  logic            srx_ok_q;
  logic            scl_drv_q;
  logic            sda_drv_q;
  logic [TWES_EV_W-1:0] ist_q;
  logic [TWES_EV_W-1:0] imk_q;
  logic [TWES_EV_W-1:0] ev_d;
  logic [31:0]     rdata_q;

  wire role    = ctrl_q[TWES_B_ROLE];
  wire xmit    = ctrl_q[TWES_B_XMIT];
  wire tmr_end = tmr_q == 10'h000;
  wire [9:0] tmr_dec = tmr_q - 10'h001;

  // arbitration: we release sda (high) but line reads low on scl high
  wire arb_lost = role & ~sda_drv_q & ~sda_s & scl_s & (st_q == TWES_M_BIT) & xmit;

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
    shift_in = {v[6:0], b};
  endfunction : shift_in

  // ****************************************
  // byte engine
  // ****************************************
  always_ff @(posedge clk_in)
  begin
    ev_d <= '0;
    if (srst_in)
    begin
      st_q      <= TWES_IDLE;
      ctrl_q    <= TWES_CTRL_RST;
      data_q    <= TWES_DATA_RST;
      sh_q      <= 8'h00;
      bit_q     <= 4'h0;
      tmr_q     <= 10'h000;
      first_q   <= 1'b0;
      sel_q     <= 1'b0;
      srx_ok_q  <= 1'b0;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
      ev_d      <= '0;
    end
    else
    begin
      tmr_q <= tmr_end ? 10'h000 : tmr_dec;
      if (wr_data)
        data_q <= wd;
      if (wr_ctrl)
      begin
        ctrl_q <= wd & 8'hd7;
        ctrl_q[TWES_B_ADDR]  <= ctrl_q[TWES_B_ADDR] & ~wd[TWES_B_PROCEED];
        ctrl_q[TWES_B_RSTOP] <= ctrl_q[TWES_B_RSTOP] & ~wd[TWES_B_PROCEED];
      end
      if (bus_start & ~role)
      begin
        first_q  <= 1'b1;
        sel_q    <= 1'b0;
        bit_q    <= 4'h0;
        st_q     <= TWES_S_BIT;
        sda_drv_q <= 1'b0;
      end
      else if (bus_stop & (st_q == TWES_ARB_WAIT))
      begin
        ev_d[TWES_EV_ARB] <= 1'b1;
        st_q <= TWES_IDLE;
      end
      else if (bus_stop & ~role & sel_q)
      begin
        sel_q <= 1'b0;
        st_q  <= TWES_IDLE;
        if (srx_ok_q)
        begin
          ctrl_q[TWES_B_RSTOP]   <= 1'b1;
          ctrl_q[TWES_B_PROCEED] <= 1'b0;
          ev_d[TWES_EV_STOP]     <= 1'b1;
        end
      end
      else if (arb_lost)
      begin
        ctrl_q[TWES_B_ROLE]   <= 1'b0;
        ctrl_q[TWES_B_ARB_RS] <= 1'b1;
        scl_drv_q <= 1'b0;
        sda_drv_q <= 1'b0;
        st_q      <= TWES_ARB_WAIT;
      end
      else
      begin
        case (st_q)
          TWES_IDLE:
            if (go & wd[TWES_B_ROLE])
            begin
              sh_q  <= data_q;
              st_q  <= TWES_M_START;
              tmr_q <= TWES_THALF;
            end
          TWES_M_START:
            if (tmr_end)
            begin
              // start, or repeated start when restart bit set
              sda_drv_q <= 1'b1;
              ctrl_q[TWES_B_ARB_RS] <= 1'b0;
              bit_q <= 4'h0;
              tmr_q <= TWES_THALF;
              st_q  <= TWES_M_BIT;
            end
          TWES_M_BIT:
            if (tmr_end)
            begin
              tmr_q <= TWES_THALF;
              scl_drv_q <= ~scl_drv_q;
              if (!scl_drv_q)
              begin
                if (bit_q == 4'h8)
                  st_q <= TWES_M_ACK;
                else
                begin
                  sda_drv_q <= xmit ? ~sh_q[7] : 1'b0;
                  if (xmit)
                    sh_q <= {sh_q[6:0], 1'b0};
                end
              end
              else
              begin
                if (!xmit)
                  sh_q <= shift_in(sh_q, sda_s);
                bit_q <= bit_q + 4'h1;
              end
            end
          TWES_M_ACK:
            if (tmr_end)
            begin
              tmr_q <= TWES_THALF;
              scl_drv_q <= ~scl_drv_q;
              if (!scl_drv_q)
                sda_drv_q <= ~xmit & ctrl_q[TWES_B_ACK];
              else
              begin
                if (xmit)
                  ctrl_q[TWES_B_ACK] <= ~sda_s;
                else
                  data_q <= sh_q;
                ctrl_q[TWES_B_PROCEED] <= 1'b0;
                ev_d[TWES_EV_BYTE] <= 1'b1;
                st_q <= TWES_M_WAIT;
              end
            end
          TWES_M_WAIT:
            if (go)
            begin
              tmr_q <= TWES_THALF;
              sh_q  <= data_q;
              if (!wd[TWES_B_ROLE])
              begin
                sda_drv_q <= 1'b1;
                st_q <= TWES_M_STOP;
              end
              else if (wd[TWES_B_ARB_RS])
              begin
                sda_drv_q <= 1'b0;
                st_q <= TWES_M_START;
              end
              else
              begin
                bit_q <= 4'h0;
                st_q  <= TWES_M_BIT;
              end
            end
          TWES_M_STOP:
            if (tmr_end)
            begin
              tmr_q <= TWES_THALF;
              if (scl_drv_q)
                scl_drv_q <= 1'b0;
              else
              begin
                sda_drv_q <= 1'b0;
                st_q <= TWES_IDLE;
              end
            end
          TWES_S_BIT:
            if (scl_rise)
            begin
              sh_q  <= shift_in(sh_q, sda_s);
              bit_q <= bit_q + 4'h1;
            end
            else if (scl_fall & (bit_q == 4'h8))
            begin
              if (first_q & (sh_q[7:1] != own_addr_in))
                st_q <= TWES_IDLE;
              else
              begin
                if (first_q)
                  sel_q <= 1'b1;
                if (!first_q & xmit)
                  st_q <= TWES_S_ACK;
                else
                begin
                  sda_drv_q <= ctrl_q[TWES_B_ACK] | first_q;
                  st_q <= TWES_S_ACK;
                end
              end
            end
            else if (scl_fall & xmit & sel_q & ~first_q)
              sda_drv_q <= ~sh_q[7 - bit_q[2:0]];
          TWES_S_ACK:
            if (scl_rise & xmit & ~first_q)
              ctrl_q[TWES_B_ACK] <= ~sda_s;
            else if (scl_fall)
            begin
              sda_drv_q <= 1'b0;
              scl_drv_q <= 1'b1;
              if (!xmit | first_q)
                data_q <= sh_q;
              srx_ok_q <= ctrl_q[TWES_B_ACK] | first_q;
              ctrl_q[TWES_B_ADDR]    <= first_q;
              ctrl_q[TWES_B_PROCEED] <= 1'b0;
              ev_d[TWES_EV_BYTE]     <= 1'b1;
              first_q <= 1'b0;
              st_q    <= TWES_S_WAIT;
            end
          TWES_S_WAIT:
            if (go)
            begin
              // clock stretch ends once firmware proceeds
              scl_drv_q <= 1'b0;
              sh_q  <= data_q;
              bit_q <= 4'h0;
              st_q  <= TWES_S_BIT;
            end
          TWES_ARB_WAIT:
            st_q <= TWES_ARB_WAIT;
          default:
            st_q <= TWES_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // interrupt status, mask and read data
  // ****************************************
  wire [TWES_EV_W-1:0] ist_clr = (wr & hit_ist) ? wd[TWES_EV_W-1:0] : '0;
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ist_q   <= '0;
      imk_q   <= '0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ist_q <= (ist_q & ~ist_clr) | ev_d; // set wins
      if (wr & hit_imk)
        imk_q <= wd[TWES_EV_W-1:0];
      if (apb_in.psel & ~apb_in.penable & ~apb_in.pwrite)
      begin
        if (hit_ctrl)
          rdata_q <= {24'h000000, ctrl_q};
        else if (hit_data)
          rdata_q <= {24'h000000, data_q};
        else if (hit_ist)
          rdata_q <= {29'h0, ist_q};
        else if (hit_imk)
          rdata_q <= {29'h0, imk_q};
        else
          rdata_q <= 32'h0000_0000;
      end
    end
  end

  // pulse in the cycle the control flags settle, one cycle before the status flags
  assign event_pulse_out = |ev_d;
  assign irq_out    = ctrl_q[TWES_B_IEN] & |(ist_q & imk_q);
  assign prdata_out = rdata_q;
  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe_out = scl_drv_q;
  assign sda_oe_out = sda_drv_q;

endmodule : twes_top
`default_nettype wire
